/* can_timing_consts.svh */
// Register offsets, field positions, reset values and timing counts of the CAN timing and page block
`ifndef CAN_TIMING_CONSTS_SVH
`define CAN_TIMING_CONSTS_SVH

// Byte offsets on the register bus
`define OFS_BIT_TIMING_ONE      8'h00
`define OFS_BIT_TIMING_TWO      8'h04
`define OFS_BIT_TIMING_THREE    8'h08
`define OFS_TIMER_PRESCALE_CTRL 8'h0c
`define OFS_TIMER_COUNT         8'h10
`define OFS_TRIGGER_CAPTURE     8'h14
`define OFS_TX_ERROR_COUNT      8'h18
`define OFS_RX_ERROR_COUNT      8'h1c
`define OFS_PRIORITY_OBJECT     8'h20
`define OFS_OBJECT_PAGE_SELECT  8'h24
`define OFS_CONTROLLER_CTRL     8'h28
`define OFS_DATA_WINDOW         8'h2c
`define OFS_OBJECT_IRQ_STATUS   8'h30

// Field positions
`define BT1_PRESCALE_MSB  6
`define BT1_PRESCALE_LSB  1
`define BT2_JUMP_MSB      6
`define BT2_JUMP_LSB      5
`define BT2_PROP_MSB      3
`define BT2_PROP_LSB      1
`define BT3_PH2_MSB       6
`define BT3_PH2_LSB       4
`define BT3_PH1_MSB       3
`define BT3_PH1_LSB       1
`define BT3_TRIPLE_BIT    0
`define PAGE_OBJ_MSB      7
`define PAGE_OBJ_LSB      4
`define PAGE_HOLD_BIT     3
`define PAGE_IDX_MSB      2
`define PAGE_IDX_LSB      0
`define HP_TOP_MSB        7
`define HP_TOP_LSB        4
`define HP_GP_MSB         3
`define HP_GP_LSB         0
`define CTRL_ENABLE_BIT   0

// Reset values
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define NO_PENDING_OBJECT 4'hf

// Timer clock is the I/O clock divided by eight times (prescale + 1)
`define TIMER_DIV_LOW_BITS 3'h7

`endif

/* can_timing_pkg.sv */
// Types shared by the CAN timing and page block
package can_timing_pkg;

  // Segments of one nominal bit time
  typedef enum logic [3:0] {
    SEG_SYNC = 4'b0001,
    SEG_PROP = 4'b0010,
    SEG_PH1  = 4'b0100,
    SEG_PH2  = 4'b1000
  } seg_state_t;

endpackage : can_timing_pkg

/* can_timing_page.sv */
// CAN bit timing, prescaled timer, error counters, priority indicator and page register
`timescale 1ns/1ns
`include "can_timing_consts.svh"

module can_timing_page #(
  parameter int NUM_OBJ = 6
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               bus_line_pin_i,
  input  wire logic               ttc_capture_i,
  input  wire logic [7:0]         tx_fault_tally_i,
  input  wire logic [7:0]         rx_fault_tally_i,
  input  wire logic [NUM_OBJ-1:0] object_irq_set_i,
  input  wire logic [NUM_OBJ-1:0] object_irq_clr_i,
  input  wire logic [7:0]         buf_rdata_i,
  output logic      [3:0]         buf_obj_o,
  output logic      [2:0]         buf_idx_o,
  output logic                    buf_rd_o,
  output logic                    buf_wr_o,
  output logic      [2:0]         buf_wr_idx_o,
  output logic      [7:0]         buf_wdata_o,
  output logic                    time_quantum_o,
  output logic                    sample_valid_o,
  output logic                    sampled_bit_o,
  output logic                    bit_start_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [5:0]         quantum_prescale;
  logic [1:0]         jump_width;
  logic [2:0]         prop_len;
  logic [2:0]         phase_two_len;
  logic [2:0]         phase_one_len;
  logic               triple_sample_sel;
  logic [7:0]         timer_prescale;
  logic [15:0]        timer_count_value;
  logic [15:0]        trigger_capture_value;
  logic [7:0]         tx_fault_tally;
  logic [7:0]         rx_fault_tally;
  logic [3:0]         general_purpose_nibble;
  logic [3:0]         top_pending_object;
  logic [3:0]         object_select;
  logic               index_hold_n;
  logic [2:0]         byte_index;
  logic [NUM_OBJ-1:0] object_irq_status;
  logic               ctrl_enable;

  // Bus request is taken while no answer is outstanding
  logic        req;
  logic        wr_req;
  logic        buf_access;
  logic [31:0] next_rdata;

  assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_req     = req & wb_we_i & wb_sel_i[0];
  assign buf_access = req & (wb_adr_i == `OFS_DATA_WINDOW) & (~wb_we_i | wb_sel_i[0]);

  // Low byte write strobe for one register, reused by every writable register
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_req & (wb_adr_i == ofs);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? next_rdata : 32'h0000_0000;
    end
  end

  // Read multiplexer; reserved bits come back as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_BIT_TIMING_ONE:      next_rdata[7:0] = {1'b0, quantum_prescale, 1'b0};
      `OFS_BIT_TIMING_TWO:      next_rdata[7:0] = {1'b0, jump_width, 1'b0, prop_len, 1'b0};
      `OFS_BIT_TIMING_THREE:    next_rdata[7:0] = {1'b0, phase_two_len, phase_one_len, triple_sample_sel};
      `OFS_TIMER_PRESCALE_CTRL: next_rdata[7:0] = timer_prescale;
      `OFS_TIMER_COUNT:         next_rdata[15:0] = timer_count_value;
      `OFS_TRIGGER_CAPTURE:     next_rdata[15:0] = trigger_capture_value;
      `OFS_TX_ERROR_COUNT:      next_rdata[7:0] = tx_fault_tally;
      `OFS_RX_ERROR_COUNT:      next_rdata[7:0] = rx_fault_tally;
      `OFS_PRIORITY_OBJECT:     next_rdata[7:0] = {top_pending_object, general_purpose_nibble};
      `OFS_OBJECT_PAGE_SELECT:  next_rdata[7:0] = {object_select, index_hold_n, byte_index};
      `OFS_CONTROLLER_CTRL:     next_rdata[0] = ctrl_enable;
      `OFS_DATA_WINDOW:         next_rdata[7:0] = buf_rdata_i;
      `OFS_OBJECT_IRQ_STATUS:   next_rdata[NUM_OBJ-1:0] = object_irq_status;
      default:                  next_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing configuration; reserved bits are simply not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quantum_prescale  <= 6'h00;
      jump_width        <= 2'h0;
      prop_len          <= 3'h0;
      phase_two_len     <= 3'h0;
      phase_one_len     <= 3'h0;
      triple_sample_sel <= 1'b0;
    end else begin
      if (wr_hit(`OFS_BIT_TIMING_ONE))
        quantum_prescale <= wb_dat_i[`BT1_PRESCALE_MSB:`BT1_PRESCALE_LSB];
      if (wr_hit(`OFS_BIT_TIMING_TWO)) begin
        jump_width <= wb_dat_i[`BT2_JUMP_MSB:`BT2_JUMP_LSB];
        prop_len   <= wb_dat_i[`BT2_PROP_MSB:`BT2_PROP_LSB];
      end
      if (wr_hit(`OFS_BIT_TIMING_THREE)) begin
        phase_two_len     <= wb_dat_i[`BT3_PH2_MSB:`BT3_PH2_LSB];
        phase_one_len     <= wb_dat_i[`BT3_PH1_MSB:`BT3_PH1_LSB];
        triple_sample_sel <= wb_dat_i[`BT3_TRIPLE_BIT];
      end
    end
  end

  // Timer prescale and controller enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_prescale <= `RST_BYTE;
      ctrl_enable    <= 1'b0;
    end else begin
      if (wr_hit(`OFS_TIMER_PRESCALE_CTRL))
        timer_prescale <= wb_dat_i[7:0];
      if (wr_hit(`OFS_CONTROLLER_CTRL))
        ctrl_enable <= wb_dat_i[`CTRL_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page register and data window index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      object_select          <= 4'h0;
      index_hold_n           <= 1'b0;
      byte_index             <= 3'h0;
      general_purpose_nibble <= 4'h0;
    end else begin
      if (wr_hit(`OFS_PRIORITY_OBJECT))
        general_purpose_nibble <= wb_dat_i[`HP_GP_MSB:`HP_GP_LSB];
      if (wr_hit(`OFS_OBJECT_PAGE_SELECT)) begin
        object_select <= wb_dat_i[`PAGE_OBJ_MSB:`PAGE_OBJ_LSB];
        index_hold_n  <= wb_dat_i[`PAGE_HOLD_BIT];
        byte_index    <= wb_dat_i[`PAGE_IDX_MSB:`PAGE_IDX_LSB];
      end else if (buf_access && !index_hold_n) begin
        byte_index <= byte_index + 3'h1;  // Wraps 7 to 0
      end
    end
  end

  // Reads are served in the request cycle; writes land one cycle later
  assign buf_obj_o = object_select;
  assign buf_idx_o = byte_index;
  assign buf_rd_o  = buf_access & ~wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_wr_o     <= 1'b0;
      buf_wr_idx_o <= 3'h0;
      buf_wdata_o  <= `RST_BYTE;
    end else begin
      buf_wr_o     <= buf_access & wb_we_i;
      buf_wr_idx_o <= byte_index;
      buf_wdata_o  <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-object interrupt status; a set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i)
      object_irq_status <= '0;
    else
      object_irq_status <= (object_irq_status & ~object_irq_clr_i) | object_irq_set_i;
  end

  // Lowest object number has the highest priority
  always_comb begin
    top_pending_object = `NO_PENDING_OBJECT;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (object_irq_status[i])
        top_pending_object = 4'(i);
    end
  end

  // Error counts mirror the protocol engine, registered for a stable read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_fault_tally <= `RST_BYTE;
      rx_fault_tally <= `RST_BYTE;
    end else begin
      tx_fault_tally <= tx_fault_tally_i;
      rx_fault_tally <= rx_fault_tally_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CAN timer: divider restarts on disable so the first tick is a full period
  logic [10:0] timer_div;
  logic [10:0] timer_div_last;
  logic        timer_tick;

  assign timer_div_last = {timer_prescale, `TIMER_DIV_LOW_BITS};
  assign timer_tick     = ctrl_enable & (timer_div == timer_div_last);

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_enable)
      timer_div <= 11'h000;
    else if (timer_tick)
      timer_div <= 11'h000;
    else
      timer_div <= timer_div + 11'h001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count_value     <= `RST_WORD;
      trigger_capture_value <= `RST_WORD;
    end else begin
      if (timer_tick)
        timer_count_value <= timer_count_value + 16'h0001;
      if (ttc_capture_i)
        trigger_capture_value <= timer_count_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time quantum prescaler
  logic [5:0] quantum_cnt;
  logic       quantum_tick;

  assign quantum_tick   = ctrl_enable & (quantum_cnt == quantum_prescale);
  assign time_quantum_o = quantum_tick;

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_enable || quantum_tick)
      quantum_cnt <= 6'h00;
    else
      quantum_cnt <= quantum_cnt + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit segment sequencer with resynchronisation on falling edges
  can_timing_pkg::seg_state_t seg_state;
  can_timing_pkg::seg_state_t next_seg_state;
  logic [3:0] seg_q;
  logic [3:0] seg_len;
  logic [2:0] ext_q;
  logic       short_q;
  logic [2:0] rx_hist;
  logic       edge_fall;
  logic       seg_done;
  logic       sample_now;
  logic [2:0] jump_quanta;
  logic [3:0] ph2_left;

  assign edge_fall   = rx_hist[0] & ~bus_line_pin_i;
  assign jump_quanta = {1'b0, jump_width} + 3'h1;
  assign ph2_left    = {1'b0, phase_two_len} - seg_q;

  // Segment lengths in quanta, phase one stretched by the first late edge of the bit
  always_comb begin
    case (seg_state)
      can_timing_pkg::SEG_SYNC: seg_len = 4'h1;
      can_timing_pkg::SEG_PROP: seg_len = {1'b0, prop_len} + 4'h1;
      can_timing_pkg::SEG_PH1:  seg_len = {1'b0, phase_one_len} + 4'h1 + {1'b0, ext_q};
      can_timing_pkg::SEG_PH2:  seg_len = {1'b0, phase_two_len} + 4'h1;
      default:                  seg_len = 4'h1;
    endcase
  end

  assign seg_done = quantum_tick & ((seg_q == seg_len - 4'h1) | ((seg_state == can_timing_pkg::SEG_PH2) & short_q));
  assign sample_now = seg_done & (seg_state == can_timing_pkg::SEG_PH1);

  always_comb begin
    case (seg_state)
      can_timing_pkg::SEG_SYNC: next_seg_state = can_timing_pkg::SEG_PROP;
      can_timing_pkg::SEG_PROP: next_seg_state = can_timing_pkg::SEG_PH1;
      can_timing_pkg::SEG_PH1:  next_seg_state = can_timing_pkg::SEG_PH2;
      can_timing_pkg::SEG_PH2:  next_seg_state = can_timing_pkg::SEG_SYNC;
      default:                  next_seg_state = can_timing_pkg::SEG_SYNC;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_enable) begin
      seg_state <= can_timing_pkg::SEG_SYNC;
      seg_q     <= 4'h0;
    end else if (seg_done) begin
      seg_state <= next_seg_state;
      seg_q     <= 4'h0;
    end else if (quantum_tick) begin
      seg_q <= seg_q + 4'h1;
    end
  end

  // Late edge lengthens phase one once per bit; early edge may end phase two
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_enable || (seg_done && seg_state == can_timing_pkg::SEG_PH2)) begin
      ext_q   <= 3'h0;
      short_q <= 1'b0;
    end else begin
      if (edge_fall && ext_q == 3'h0 &&
          (seg_state == can_timing_pkg::SEG_PROP || seg_state == can_timing_pkg::SEG_PH1))
        ext_q <= jump_quanta;
      if (edge_fall && seg_state == can_timing_pkg::SEG_PH2 && ph2_left <= {1'b0, jump_quanta})
        short_q <= 1'b1;  // Shorter than the jump width allows is ignored
    end
  end

  // Three-deep history gives the samples two and one clocks before the point
  always_ff @(posedge clk_i) begin
    if (rst_i)
      rx_hist <= 3'h7;
    else
      rx_hist <= {rx_hist[1:0], bus_line_pin_i};
  end

  // Sampled level; triple mode votes, single mode takes the point itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_valid_o <= 1'b0;
      sampled_bit_o  <= 1'b1;
      bit_start_o    <= 1'b0;
    end else begin
      sample_valid_o <= sample_now;
      bit_start_o    <= seg_done & (seg_state == can_timing_pkg::SEG_PH2);
      if (sample_now && triple_sample_sel)
        sampled_bit_o <= (rx_hist[1] & rx_hist[0]) | (rx_hist[1] & bus_line_pin_i)
                         | (rx_hist[0] & bus_line_pin_i);
      else if (sample_now)
        sampled_bit_o <= bus_line_pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking chk_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [11:0] seg_clk;
  logic [10:0] tmr_gap;
  logic        tmr_seen;
  logic [11:0] seg_expect;

  assign seg_expect = {8'h00, seg_len} * ({6'h00, quantum_prescale} + 12'h001);

  // Cycles spent in the current segment and between timer ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_enable || seg_done)
      seg_clk <= 12'h000;
    else
      seg_clk <= seg_clk + 12'h001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_enable) begin
      tmr_gap  <= 11'h000;
      tmr_seen <= 1'b0;
    end else if (timer_tick) begin
      tmr_gap  <= 11'h000;
      tmr_seen <= 1'b1;
    end else begin
      tmr_gap <= tmr_gap + 11'h001;
    end
  end

  sequence access_s;
    buf_access && !index_hold_n && !wr_hit(`OFS_OBJECT_PAGE_SELECT);
  endsequence

  sequence single_point_s;
    sample_now && !triple_sample_sel;
  endsequence

  chk_phase_two_len: assert property (
    (seg_done && seg_state == can_timing_pkg::SEG_PH2 && !short_q) |-> (seg_clk + 12'h001 == seg_expect))
    else $error("phase two length wrong");

  chk_phase_one_len: assert property (
    (seg_done && seg_state == can_timing_pkg::SEG_PH1) |-> (seg_clk + 12'h001 == seg_expect))
    else $error("phase one length wrong");

  chk_single_sample: assert property (
    single_point_s |=> (sample_valid_o && sampled_bit_o == $past(bus_line_pin_i)))
    else $error("single sample differs from line");

  chk_triple_vote: assert property (
    (sample_now && triple_sample_sel) |=> sampled_bit_o ==
      (($past(bus_line_pin_i, 1) & $past(bus_line_pin_i, 2)) | ($past(bus_line_pin_i, 1) & $past(bus_line_pin_i, 3))
       | ($past(bus_line_pin_i, 2) & $past(bus_line_pin_i, 3))))
    else $error("majority vote wrong");

  chk_timer_period: assert property (
    (timer_tick && tmr_seen && $stable(timer_prescale)) |-> tmr_gap == timer_div_last)
    else $error("timer period wrong");

  chk_timer_stop: assert property (
    !ctrl_enable |=> $stable(timer_count_value))
    else $error("timer moved while disabled");

  chk_capture_copy: assert property (
    ttc_capture_i |=> trigger_capture_value == $past(timer_count_value))
    else $error("capture did not copy timer");

  chk_none_pending: assert property (
    (object_irq_status == '0) |-> top_pending_object == `NO_PENDING_OBJECT)
    else $error("indicator not all ones when idle");

  chk_top_object: assert property (
    object_irq_status[0] |-> top_pending_object == 4'h0)
    else $error("object zero not reported first");

  chk_index_step: assert property (
    access_s |=> byte_index == $past(byte_index) + 3'h1)
    else $error("index did not advance");

  chk_index_hold: assert property (
    (buf_access && index_hold_n && !wr_hit(`OFS_OBJECT_PAGE_SELECT)) |=> $stable(byte_index))
    else $error("held index moved");

  chk_irq_set_wins: assert property (
    |object_irq_set_i |=> ((object_irq_status & $past(object_irq_set_i)) == $past(object_irq_set_i)))
    else $error("status set was lost");

endmodule : can_timing_page

/* can_far_side.sv */
// Far-side model: message object data buffers and the received bus level
`timescale 1ns/1ns
module can_far_side (
  input  wire logic       clk_i,
  input  wire logic       level_i,
  input  wire logic [3:0] obj_i,
  input  wire logic [2:0] idx_i,
  input  wire logic       wr_i,
  input  wire logic [2:0] wr_idx_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            line_o
);
  logic [7:0] mem [0:15][0:7];

  // Each byte starts as a pattern of its object and index, so a wrong select shows
  initial begin
    for (int o = 0; o < 16; o++)
      for (int i = 0; i < 8; i++)
        mem[o][i] = {o[3:0], 1'b1, i[2:0]};
  end

  // A write carries its own index, since the live index may already have moved
  always @(posedge clk_i) begin
    if (wr_i) mem[obj_i][wr_idx_i] <= wdata_i;
  end

  assign rdata_o = mem[obj_i][idx_i];
  assign line_o  = level_i;  // Recessive is 1
endmodule : can_far_side

/* can_timing_page_bench.sv */
// Self-checking bench for the CAN timing and page block
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module can_timing_page_bench;
  typedef struct packed {logic we; logic [7:0] adr; logic [7:0] wd; logic [15:0] ex;} row_t;
  logic        clk_i, rst_i, cyc, stb, we, ttc, lvl, brd, bwr, line;
  logic [7:0]  adr, tx, rx, brdat, bwd;
  logic [31:0] wdat, rdat;
  logic [5:0]  iset, iclr;
  logic        ack, qtick, sv, sb, bs;
  logic [3:0]  bobj;
  logic [2:0]  bidx, bwidx;
  logic [15:0] q, v0, v1;
  int          err_count, comparisons, cycles, n, m, rd_pulses;
  row_t        rows [9];

  can_timing_page can_timing_page_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bus_line_pin_i(line), .ttc_capture_i(ttc), .tx_fault_tally_i(tx), .rx_fault_tally_i(rx),
    .object_irq_set_i(iset), .object_irq_clr_i(iclr), .buf_rdata_i(brdat), .buf_obj_o(bobj),
    .buf_idx_o(bidx), .buf_rd_o(brd), .buf_wr_o(bwr), .buf_wr_idx_o(bwidx), .buf_wdata_o(bwd),
    .time_quantum_o(qtick), .sample_valid_o(sv), .sampled_bit_o(sb), .bit_start_o(bs));
  can_far_side can_far_side_inst (.clk_i(clk_i), .level_i(lvl), .obj_i(bobj), .idx_i(bidx),
    .wr_i(bwr), .wr_idx_i(bwidx), .wdata_i(bwd), .rdata_o(brdat), .line_o(line));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling that cuts a hang short
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      err_count++;
      summarize();
    end
  end
  // Data window read strobes, one per taken read
  always @(posedge clk_i) begin
    if (brd === 1'b1) rd_pulses++;
  end

  // Classic single cycle; request held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [15:0] r);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, ttc, lvl, iset, iclr, adr, wdat} = '0;
    {rst_i, lvl, tx, rx} = {1'b1, 1'b1, 8'ha5, 8'h5a};
    // Writable fields read back what was written; writes to read-only and unmapped places leave them untouched
    rows = '{'{1'b0, 8'h20, 8'h00, 16'h00f0}, '{1'b1, 8'h20, 8'h05, 16'h00f5},
             '{1'b1, 8'h08, 8'h7e, 16'h007e}, '{1'b1, 8'h10, 8'hff, 16'h0000},
             '{1'b1, 8'h14, 8'hff, 16'h0000}, '{1'b1, 8'h18, 8'h00, 16'h00a5},
             '{1'b1, 8'h1c, 8'h00, 16'h005a}, '{1'b1, 8'h0c, 8'h03, 16'h0003},
             '{1'b1, 8'h3c, 8'hff, 16'h0000}};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].we) wb(1'b1, rows[k].adr, rows[k].wd, q);
      wb(1'b0, rows[k].adr, 8'h00, q);
      `CHK(q, rows[k].ex)
    end
    $display("register table done");
    // Lowest pending object wins; all ones once none is pending
    @(posedge clk_i) iset <= 6'h0a;
    @(posedge clk_i) iset <= 6'h00;
    wb(1'b0, 8'h20, 8'h00, q);
    `CHK(q[7:0], 8'h15)
    @(posedge clk_i) iclr <= 6'h02;
    @(posedge clk_i) iclr <= 6'h00;
    wb(1'b0, 8'h20, 8'h00, q);
    `CHK(q[7:0], 8'h35)
    @(posedge clk_i) iclr <= 6'h08;
    @(posedge clk_i) iclr <= 6'h00;
    wb(1'b0, 8'h20, 8'h00, q);
    `CHK(q[7:0], 8'hf5)
    $display("priority done");
    // Index starts near the top so the wrap from 7 to 0 is crossed
    wb(1'b1, 8'h24, 8'h26, q);  // Object 2, hold bit clear, index 6
    for (int k = 0; k < 3; k++) begin
      wb(1'b0, 8'h2c, 8'h00, q);
      `CHK(q[7:0], {4'h2, 1'b1, 3'(6 + k)})
    end
    wb(1'b0, 8'h24, 8'h00, q);
    `CHK(q[7:0], 8'h21)
    // With the hold bit set the index stays put across write and read
    wb(1'b1, 8'h24, 8'h5c, q);
    wb(1'b1, 8'h2c, 8'h9c, q);
    wb(1'b0, 8'h2c, 8'h00, q);
    `CHK(q[7:0], 8'h9c)
    wb(1'b0, 8'h24, 8'h00, q);
    `CHK(q[7:0], 8'h5c)
    `CHK(rd_pulses, 4)
    $display("page done");
    // Quantum 2 clocks; bit = 1 + 1 + 3 + 2 quanta = 14 clocks with an idle bus
    wb(1'b1, 8'h00, 8'h02, q);
    wb(1'b1, 8'h04, 8'h00, q);
    wb(1'b1, 8'h08, 8'h14, q);  // Phase two of 1 is within one and phase one
    wb(1'b1, 8'h28, 8'h01, q);
    @(posedge clk_i);
    while (bs !== 1'b1) @(posedge clk_i);
    n = 0;
    m = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (qtick === 1'b1) m++;
    end while (bs !== 1'b1);
    `CHK(n, 14)
    `CHK(m, 7)
    lvl <= 1'b0;
    repeat (2) begin @(posedge clk_i); while (sv !== 1'b1) @(posedge clk_i); end
    `CHK(sb, 1'b0)
    wb(1'b1, 8'h08, 8'h15, q);  // Triple sampling on; the vote takes the point and the two clocks before it
    lvl <= 1'b1;
    repeat (2) begin @(posedge clk_i); while (sv !== 1'b1) @(posedge clk_i); end
    `CHK(sb, 1'b1)
    $display("bit timing done");
    // Timer: 16 clocks a tick; 163 clocks enabled give exactly 10 ticks, divider restarting
    wb(1'b1, 8'h28, 8'h00, q);
    wb(1'b0, 8'h10, 8'h00, v0);
    wb(1'b1, 8'h0c, 8'h01, q);
    wb(1'b1, 8'h28, 8'h01, q);
    repeat (160) @(posedge clk_i);
    wb(1'b1, 8'h28, 8'h00, q);
    wb(1'b0, 8'h10, 8'h00, v1);
    `CHK(v1 - v0, 16'h000a)
    repeat (40) @(posedge clk_i);
    wb(1'b0, 8'h10, 8'h00, q);
    `CHK(q, v1)
    @(posedge clk_i) ttc <= 1'b1;
    @(posedge clk_i) ttc <= 1'b0;
    wb(1'b0, 8'h14, 8'h00, q);
    `CHK(q, v1)
    $display("timer done");
    // Reset in mid-run clears pending status, counts and the general nibble
    @(posedge clk_i) iset <= 6'h20;
    @(posedge clk_i) iset <= 6'h00;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h20, 8'h00, q);
    `CHK(q, 16'h00f0)
    wb(1'b0, 8'h10, 8'h00, q);
    `CHK(q, 16'h0000)
    wb(1'b0, 8'h14, 8'h00, q);
    `CHK(q, 16'h0000)
    $display("reset done");
    summarize();
  end
endmodule : can_timing_page_bench
